// file: hdl/sdm_pkg.sv
// Constants and types shared by the SDRAM mode and refresh command decoder.
package sdm_pkg;

    // ****************************************************************
    // Pin vector layout after synchronisation
    // ****************************************************************
    localparam int PIN_W = 18;
    localparam int PIN_CS = 17;
    localparam int PIN_RAS = 16;
    localparam int PIN_CAS = 15;
    localparam int PIN_WE = 14;
    localparam int PIN_CKE = 13;
    localparam int PIN_BANK_LSB = 11;
    localparam int BANK_W = 2;
    localparam int ADDR_W = 11;
    localparam logic [17:0] PIN_IDLE = 18'h3e000;

    // ****************************************************************
    // Mode register layout: bank_select above the eleven address bits
    // ****************************************************************
    localparam int MODE_W = 13;
    localparam logic [12:0] MODE_RESET = 13'h0000;
    localparam int BL_LSB = 0;
    localparam int ORDER_BIT = 3;
    localparam int LAT_LSB = 4;
    localparam int TEST_LSB = 7;
    localparam int WBS_BIT = 9;
    localparam int RSV_BIT = 10;
    localparam int PART_LSB = 11;

    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_FULL = 3'h7;
    localparam logic [2:0] LAT_2 = 3'h2;
    localparam logic [2:0] LAT_3 = 3'h3;
    localparam logic [1:0] LAT2_CYCLES = 2'h2;
    localparam logic [1:0] LAT3_CYCLES = 2'h3;

    localparam logic [1:0] PART_ALL = 2'h0;
    localparam logic [1:0] PART_HALF = 2'h1;
    localparam logic [3:0] BANKS_ALL = 4'hf;
    localparam logic [3:0] BANKS_01 = 4'h3;
    localparam logic [3:0] BANKS_0 = 4'h1;

    // ****************************************************************
    // Column and refresh timing
    // ****************************************************************
    localparam int COL_W = 8;
    localparam int REFRESH_WINDOW_US = 64000;
    localparam int REFRESH_OPS = 4096;
    localparam int CLK_MHZ = 25;
    localparam int SR_TICK_CYCLES = (REFRESH_WINDOW_US * CLK_MHZ) / REFRESH_OPS;
    localparam int SR_TIMER_W = 9;

    typedef enum logic [0:0] {
        SR_AWAKE = 1'b0,
        SR_ASLEEP = 1'b1
    } sdm_sr_e;

    typedef enum logic [1:0] {
        BS_IDLE = 2'b00,
        BS_RUN = 2'b01,
        BS_DRAIN = 2'b10
    } sdm_burst_e;

endpackage

// file: hdl/sdm_cmd_decode.sv
// Command decoder, mode register, refresh row counter and burst column sequencer.
// What this block does
// - Strobes all low loads mode register from bank_select and address pins in one cycle.
// - A2..A0 give burst length 1,2,4,8 or full page; others reserved.
// - A3 selects burst_order: sequential or interleaved, except full page bursts, which always run sequential.
// - Sequential columns increment from start, keeping only eight bits.
// - Interleaved column n is start address XOR burst index.
// - A6..A4 give read latency two or three clocks; others reserved.
// - A9 write_burst_single makes every write a single word.
// - Chip select low with all strobes high is no operation.
// - Burst stop ends bursts that carry no auto precharge.
// - A stopped read keeps delivering data for read-latency cycles.
// - Chip select high ignores strobes and address pins.
// - Auto refresh ignores address pins; internal row counter advances.
// - Refresh pattern with clock enable low enters self refresh; only clock enable heard.
// - bank_select in mode picks refresh banks: all, 0 and 1, or 0.
module sdm_cmd_decode #(
    parameter int ROW_W = 11,
    parameter int SR_TICK = sdm_pkg::SR_TICK_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Command pins from the memory controller
    input wire logic chipSelectN,
    input wire logic rowStrobeN,
    input wire logic colStrobeN,
    input wire logic writeStrobeN,
    input wire logic clockEnable,
    input wire logic [1:0] bankSelect,
    input wire logic [10:0] addrPins,
    // Burst requests from the read and write path
    input wire logic burstStart,
    input wire logic burstIsRead,
    input wire logic burstAutoPrecharge,
    input wire logic [7:0] burstStartCol,
    // Decoded command pulses
    output logic cmdNop,
    output logic cmdDeselect,
    output logic cmdBurstStop,
    output logic cmdModeLoad,
    output logic cmdAutoRefresh,
    // Mode register fields
    output logic [2:0] burstLenCode,
    output logic burstOrder,
    output logic [2:0] readLatencyCode,
    output logic [1:0] testModeCode,
    output logic writeBurstSingle,
    output logic [3:0] refreshBanks,
    // Refresh state
    output logic selfRefreshActive,
    output logic refreshPulse,
    output logic [ROW_W-1:0] refreshRow,
    // Burst column sequencer
    output logic burstActive,
    output logic colValid,
    output logic [7:0] colAddr
);

    initial begin
        if (ROW_W < 1 || ROW_W > 16 || SR_TICK < 2 || SR_TICK >= (1 << sdm_pkg::SR_TIMER_W)) begin
            $error("sdm_cmd_decode: unsupported parameter value");
        end
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [7:0] burstLastIdx(input logic [2:0] code);
        unique case (code)
            sdm_pkg::BL_1: burstLastIdx = 8'h00;
            sdm_pkg::BL_2: burstLastIdx = 8'h01;
            sdm_pkg::BL_4: burstLastIdx = 8'h03;
            sdm_pkg::BL_8: burstLastIdx = 8'h07;
            default: burstLastIdx = 8'hff;
        endcase
    endfunction

    function automatic logic [7:0] columnFor(input logic [7:0] start, input logic [7:0] idx, input logic il);
        columnFor = il ? (start ^ idx) : 8'(start + idx);
    endfunction

    // ****************************************************************
    // Pin synchroniser
    // ****************************************************************
    logic [17:0] pinMeta_ff;
    logic [17:0] pinSync_ff;
    logic [17:0] nxt_pinMeta;

    always_comb begin
        nxt_pinMeta = {chipSelectN, rowStrobeN, colStrobeN, writeStrobeN, clockEnable, bankSelect, addrPins};
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pinMeta_ff <= sdm_pkg::PIN_IDLE;
            pinSync_ff <= sdm_pkg::PIN_IDLE;
        end else begin
            pinMeta_ff <= nxt_pinMeta;
            pinSync_ff <= pinMeta_ff;
        end
    end

    // ****************************************************************
    // Command decode, mode register and refresh
    // ****************************************************************
    logic csN, rasN, casN, weN, cke;
    logic ckePrev_ff;
    logic [12:0] mode_ff, nxt_mode;
    logic [3:0] banks_ff, nxt_banks;
    sdm_pkg::sdm_sr_e sr_ff, nxt_sr;
    logic [8:0] srTimer_ff, nxt_srTimer;
    logic [ROW_W-1:0] row_ff, nxt_row;
    logic nop_ff, desel_ff, stop_ff, load_ff, aref_ff, pulse_ff;
    logic nxt_nop, nxt_desel, nxt_stop, nxt_load, nxt_aref, nxt_pulse;
    logic decLoad, decAref, decSelf, decStop;

    assign csN = pinSync_ff[sdm_pkg::PIN_CS];
    assign rasN = pinSync_ff[sdm_pkg::PIN_RAS];
    assign casN = pinSync_ff[sdm_pkg::PIN_CAS];
    assign weN = pinSync_ff[sdm_pkg::PIN_WE];
    assign cke = pinSync_ff[sdm_pkg::PIN_CKE];

    always_comb begin
        // Deselect and self refresh both mask every strobe.
        logic awake;
        awake = (sr_ff == sdm_pkg::SR_AWAKE) && !csN && ckePrev_ff;
        decLoad = awake && cke && !rasN && !casN && !weN;
        decAref = awake && cke && !rasN && !casN && weN;
        decSelf = awake && !cke && !rasN && !casN && weN;
        decStop = awake && cke && rasN && casN && !weN;
        nxt_nop = awake && cke && rasN && casN && weN;
        nxt_desel = csN && (sr_ff == sdm_pkg::SR_AWAKE);
        nxt_stop = decStop;
        nxt_load = decLoad;
        nxt_aref = decAref;
        nxt_mode = mode_ff;
        nxt_banks = banks_ff;
        nxt_sr = sr_ff;
        nxt_srTimer = srTimer_ff;
        nxt_row = row_ff;
        nxt_pulse = 1'b0;
        if (decLoad) begin
            nxt_mode = pinSync_ff[12:0];
            unique case (pinSync_ff[sdm_pkg::PIN_BANK_LSB +: sdm_pkg::BANK_W])
                sdm_pkg::PART_ALL: nxt_banks = sdm_pkg::BANKS_ALL;
                sdm_pkg::PART_HALF: nxt_banks = sdm_pkg::BANKS_01;
                default: nxt_banks = sdm_pkg::BANKS_0;
            endcase
        end
        unique case (sr_ff)
            sdm_pkg::SR_AWAKE: begin
                if (decAref) begin
                    nxt_row = row_ff + 1'b1;
                    nxt_pulse = 1'b1;
                end
                if (decSelf) begin
                    nxt_sr = sdm_pkg::SR_ASLEEP;
                    nxt_srTimer = 9'h000;
                end
            end
            sdm_pkg::SR_ASLEEP: begin
                // Internal timer paces refreshes; only clock enable is heard.
                if (cke) begin
                    nxt_sr = sdm_pkg::SR_AWAKE;
                end else if (srTimer_ff == 9'(SR_TICK - 1)) begin
                    nxt_srTimer = 9'h000;
                    nxt_row = row_ff + 1'b1;
                    nxt_pulse = 1'b1;
                end else begin
                    nxt_srTimer = srTimer_ff + 9'h001;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ckePrev_ff <= 1'b1;
            mode_ff <= sdm_pkg::MODE_RESET;
            banks_ff <= sdm_pkg::BANKS_ALL;
            sr_ff <= sdm_pkg::SR_AWAKE;
            srTimer_ff <= 9'h000;
            row_ff <= '0;
            nop_ff <= 1'b0;
            desel_ff <= 1'b0;
            stop_ff <= 1'b0;
            load_ff <= 1'b0;
            aref_ff <= 1'b0;
            pulse_ff <= 1'b0;
        end else begin
            ckePrev_ff <= cke;
            mode_ff <= nxt_mode;
            banks_ff <= nxt_banks;
            sr_ff <= nxt_sr;
            srTimer_ff <= nxt_srTimer;
            row_ff <= nxt_row;
            nop_ff <= nxt_nop;
            desel_ff <= nxt_desel;
            stop_ff <= nxt_stop;
            load_ff <= nxt_load;
            aref_ff <= nxt_aref;
            pulse_ff <= nxt_pulse;
        end
    end

    assign cmdNop = nop_ff;
    assign cmdDeselect = desel_ff;
    assign cmdBurstStop = stop_ff;
    assign cmdModeLoad = load_ff;
    assign cmdAutoRefresh = aref_ff;
    assign burstLenCode = mode_ff[sdm_pkg::BL_LSB +: 3];
    assign burstOrder = mode_ff[sdm_pkg::ORDER_BIT];
    assign readLatencyCode = mode_ff[sdm_pkg::LAT_LSB +: 3];
    assign testModeCode = mode_ff[sdm_pkg::TEST_LSB +: 2];
    assign writeBurstSingle = mode_ff[sdm_pkg::WBS_BIT];
    assign refreshBanks = banks_ff;
    assign selfRefreshActive = (sr_ff == sdm_pkg::SR_ASLEEP);
    assign refreshPulse = pulse_ff;
    assign refreshRow = row_ff;

    // ****************************************************************
    // Burst column sequencer
    // ****************************************************************
    sdm_pkg::sdm_burst_e bs_ff, nxt_bs;
    logic [7:0] start_ff, nxt_start;
    logic [7:0] idx_ff, nxt_idx;
    logic [7:0] last_ff, nxt_last;
    logic full_ff, nxt_full;
    logic il_ff, nxt_il;
    logic read_ff, nxt_read;
    logic ap_ff, nxt_ap;
    logic [1:0] drain_ff, nxt_drain;
    logic [7:0] col_ff, nxt_col;

    always_comb begin
        logic [7:0] stepIdx;
        logic [1:0] latCycles;
        stepIdx = idx_ff + 8'h01;
        latCycles = (readLatencyCode == sdm_pkg::LAT_3) ? sdm_pkg::LAT3_CYCLES : sdm_pkg::LAT2_CYCLES;
        nxt_bs = bs_ff;
        nxt_start = start_ff;
        nxt_idx = idx_ff;
        nxt_last = last_ff;
        nxt_full = full_ff;
        nxt_il = il_ff;
        nxt_read = read_ff;
        nxt_ap = ap_ff;
        nxt_drain = drain_ff;
        nxt_col = col_ff;
        if (burstStart && !selfRefreshActive) begin
            nxt_bs = sdm_pkg::BS_RUN;
            nxt_start = burstStartCol;
            nxt_idx = 8'h00;
            nxt_read = burstIsRead;
            nxt_ap = burstAutoPrecharge;
            nxt_il = burstOrder && (burstLenCode != sdm_pkg::BL_FULL);
            nxt_full = (burstLenCode == sdm_pkg::BL_FULL);
            nxt_last = burstLastIdx(burstLenCode);
            if (!burstIsRead && writeBurstSingle) begin
                nxt_full = 1'b0;
                nxt_last = 8'h00;
            end
            nxt_col = burstStartCol;
        end else begin
            unique case (bs_ff)
                sdm_pkg::BS_IDLE: begin
                    nxt_bs = sdm_pkg::BS_IDLE;
                end
                sdm_pkg::BS_RUN: begin
                    if (decStop && !ap_ff) begin
                        nxt_bs = read_ff ? sdm_pkg::BS_DRAIN : sdm_pkg::BS_IDLE;
                        nxt_drain = latCycles;
                    end else if (!full_ff && idx_ff == last_ff) begin
                        nxt_bs = sdm_pkg::BS_IDLE;
                    end else begin
                        nxt_idx = stepIdx;
                        nxt_col = columnFor(start_ff, stepIdx, il_ff);
                    end
                end
                sdm_pkg::BS_DRAIN: begin
                    nxt_drain = drain_ff - 2'h1;
                    if (drain_ff == 2'h1) begin
                        nxt_bs = sdm_pkg::BS_IDLE;
                    end
                end
                default: begin
                    nxt_bs = sdm_pkg::BS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            bs_ff <= sdm_pkg::BS_IDLE;
            start_ff <= 8'h00;
            idx_ff <= 8'h00;
            last_ff <= 8'h00;
            full_ff <= 1'b0;
            il_ff <= 1'b0;
            read_ff <= 1'b0;
            ap_ff <= 1'b0;
            drain_ff <= 2'h0;
            col_ff <= 8'h00;
        end else begin
            bs_ff <= nxt_bs;
            start_ff <= nxt_start;
            idx_ff <= nxt_idx;
            last_ff <= nxt_last;
            full_ff <= nxt_full;
            il_ff <= nxt_il;
            read_ff <= nxt_read;
            ap_ff <= nxt_ap;
            drain_ff <= nxt_drain;
            col_ff <= nxt_col;
        end
    end

    assign burstActive = (bs_ff != sdm_pkg::BS_IDLE);
    assign colValid = (bs_ff == sdm_pkg::BS_RUN);
    assign colAddr = col_ff;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_mode_load_capture: assert property (decLoad |=> mode_ff == $past(pinSync_ff[12:0]) && cmdModeLoad)
        else $error("mode register did not capture the pins");
    a_mode_hold_nop: assert property (!decLoad |=> $stable(mode_ff))
        else $error("mode register changed without a load");
    a_deselect_ignore: assert property (csN && !selfRefreshActive |=> cmdDeselect && !cmdModeLoad && !cmdAutoRefresh
        && !cmdNop && !cmdBurstStop)
        else $error("command decoded while deselected");
    a_refresh_row_step: assert property (decAref |=> refreshRow == ROW_W'($past(refreshRow) + 1'b1) && refreshPulse)
        else $error("auto refresh did not advance the row");
    a_self_hold: assert property (selfRefreshActive && !cke |=> selfRefreshActive && !cmdModeLoad
        && !cmdAutoRefresh)
        else $error("self refresh left or decoded while clock enable low");
    a_seq_wrap: assert property (colValid && $past(colValid) && !$past(burstStart) && !il_ff
        |-> colAddr == 8'($past(colAddr) + 8'h01))
        else $error("sequential column did not step with wrap");
    a_interleave_xor: assert property (colValid && il_ff |-> colAddr == (start_ff ^ idx_ff))
        else $error("interleaved column is not start xor index");
    a_read_stop_drain: assert property (bs_ff == sdm_pkg::BS_RUN && decStop && !ap_ff && read_ff && !burstStart
        && readLatencyCode == sdm_pkg::LAT_2 ##1 !burstStart ##1 !burstStart |-> burstActive && !colValid
        ##1 !burstActive)
        else $error("stopped read did not drain for two cycles");
    a_write_stop_end: assert property (bs_ff == sdm_pkg::BS_RUN && decStop && !ap_ff && !read_ff && !burstStart
        |=> !burstActive)
        else $error("stopped write kept running");
    a_single_write: assert property (burstStart && !burstIsRead && writeBurstSingle && !selfRefreshActive
        ##1 !burstStart |-> colValid ##1 !colValid)
        else $error("single write lasted more than one word");
    a_part_banks: assert property (decLoad && pinSync_ff[12:11] == sdm_pkg::PART_HALF
        |=> refreshBanks == sdm_pkg::BANKS_01)
        else $error("partial refresh bank set wrong");

endmodule

// file: test/sdm_ctrl_model.sv
// Behavioural memory controller that drives the command pins of the decoder.
module sdm_ctrl_model #(
    parameter int TRC_CYC = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Requests from the bench
    input wire logic opGo,
    input wire logic [2:0] opCode,
    input wire logic [12:0] opData,
    output logic ready,
    // Command pins
    output logic chipSelectN,
    output logic rowStrobeN,
    output logic colStrobeN,
    output logic writeStrobeN,
    output logic clockEnable,
    output logic [1:0] bankSelect,
    output logic [10:0] addrPins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic asleep_ff;
    logic nopGap_ff;
    logic [3:0] gap_ff;
    logic [3:0] pins_ff;
    logic [12:0] addr_ff;
    logic [15:0] noise_ff;
    assign ready = gap_ff == 4'h0;
    assign {chipSelectN, rowStrobeN, colStrobeN, writeStrobeN} = pins_ff;
    assign {bankSelect, addrPins} = addr_ff;
    // Pins that carry nothing show a pattern that changes every cycle.
    always_ff @(posedge ref_clk) begin
        noise_ff <= {noise_ff[14:0], noise_ff[15] ^ noise_ff[13] ^ noise_ff[12] ^ noise_ff[10]};
        addr_ff <= noise_ff[12:0];
        pins_ff <= {1'b1, noise_ff[2:0]};
        if (gap_ff != 4'h0) begin
            gap_ff <= gap_ff - 4'h1;
            pins_ff <= nopGap_ff ? 4'h7 : {1'b1, noise_ff[2:0]};
        end
        if (sys_rst) begin
            noise_ff <= 16'hace1;
            asleep_ff <= 1'b0;
            gap_ff <= 4'h0;
            clockEnable <= 1'b1;
        end else if (asleep_ff) begin
            pins_ff <= noise_ff[3:0];
            if (opGo && opCode == 3'h6) begin
                asleep_ff <= 1'b0;
                clockEnable <= 1'b1;
                pins_ff <= {1'b1, noise_ff[2:0]};
                gap_ff <= 4'(TRC_CYC);
                nopGap_ff <= 1'b0;
            end
        end else if (opGo && ready) begin
            case (opCode)
                3'h0: pins_ff <= 4'h7;
                3'h2: pins_ff <= 4'h6;
                3'h3: begin
                    pins_ff <= 4'h0;
                    addr_ff <= opData & 13'h1a7f;
                end
                3'h4: begin
                    pins_ff <= 4'h1;
                    gap_ff <= 4'(TRC_CYC);
                    nopGap_ff <= 1'b1;
                end
                3'h5: begin
                    pins_ff <= 4'h1;
                    clockEnable <= 1'b0;
                    asleep_ff <= 1'b1;
                end
                default: begin
                end
            endcase
        end
    end
endmodule

// file: test/tb.sv
// Self-checking bench for the command decoder with a behavioural controller on its pins.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 6;
    localparam int TRC = 4;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic opGo = 1'b0;
    logic [2:0] opCode = 3'h0;
    logic [12:0] opData = 13'h0000;
    logic burstStart = 1'b0;
    logic burstIsRead = 1'b0;
    logic burstAutoPrecharge = 1'b0;
    logic [7:0] burstStartCol = 8'h00;
    logic ready, chipSelectN, rowStrobeN, colStrobeN, writeStrobeN, clockEnable, burstOrder, writeBurstSingle;
    logic cmdNop, cmdDeselect, cmdBurstStop, cmdModeLoad, cmdAutoRefresh;
    logic selfRefreshActive, refreshPulse, burstActive, colValid, pageRun;
    logic [1:0] bankSelect, testModeCode;
    logic [2:0] burstLenCode, readLatencyCode;
    logic [3:0] refreshBanks;
    logic [7:0] colAddr, pagePrev;
    logic [10:0] addrPins, refreshRow;
    logic [12:0] modeNow;
    logic [31:0] seed = 32'h0000c55e;
    logic [15:0] expQ [1:6][$];
    int errors = 0;
    int checked = 0;
    int deselCnt = 0;
    int pulses = 0;
    sdm_ctrl_model #(.TRC_CYC(TRC)) sdm_ctrl_model_i (.ref_clk, .sys_rst, .opGo, .opCode, .opData, .ready,
        .chipSelectN, .rowStrobeN, .colStrobeN, .writeStrobeN, .clockEnable, .bankSelect, .addrPins);
    sdm_cmd_decode #(.ROW_W(11), .SR_TICK(TICK)) sdm_cmd_decode_i (.ref_clk, .sys_rst, .chipSelectN,
        .rowStrobeN, .colStrobeN, .writeStrobeN, .clockEnable, .bankSelect, .addrPins, .burstStart,
        .burstIsRead, .burstAutoPrecharge, .burstStartCol, .cmdNop, .cmdDeselect, .cmdBurstStop, .cmdModeLoad,
        .cmdAutoRefresh, .burstLenCode, .burstOrder, .readLatencyCode, .testModeCode, .writeBurstSingle,
        .refreshBanks, .selfRefreshActive, .refreshPulse, .refreshRow, .burstActive, .colValid, .colAddr);
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic close_out();
        if (errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic stall();
        errors++;
        close_out();
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic take(input int k, input logic [15:0] got);
        check(got, expQ[k].size() > 0 ? expQ[k].pop_front() : 16'hffff);
    endtask
    task automatic send(input logic [2:0] code, input logic [12:0] data);
        int i;
        @(posedge ref_clk);
        for (i = 0; i < 40 && ready !== 1'b1; i++) @(posedge ref_clk);
        if (ready !== 1'b1) stall();
        opGo <= 1'b1;
        opCode <= code;
        opData <= data;
        @(posedge ref_clk);
        opGo <= 1'b0;
    endtask
    task automatic ldMode(input logic [12:0] d);
        modeNow = d & 13'h1a7f;
        expQ[4].push_back({2'h0, modeNow[2:0], modeNow[3], modeNow[6:4], 2'h0, modeNow[9], modeNow[12:11] == 2'h0 ?
            4'hf : modeNow[12:11] == 2'h1 ? 4'h3 : 4'h1});
        send(3'h3, d);
        repeat (5) @(posedge ref_clk);
    endtask
    task automatic burst(input logic rd, input logic ap, input logic [7:0] col);
        int n, i;
        n = modeNow[2:0] == 3'h7 ? 0 : 1 << modeNow[1:0];
        if (!rd && modeNow[9]) n = 1;
        for (i = 0; i < n; i++) expQ[6].push_back({8'h01, modeNow[3] ? col ^ 8'(i) : col + 8'(i)});
        @(posedge ref_clk);
        burstStart <= 1'b1;
        burstIsRead <= rd;
        burstAutoPrecharge <= ap;
        burstStartCol <= col;
        @(posedge ref_clk);
        burstStart <= 1'b0;
    endtask
    // Nop, stop, load and refresh pulses and non-page columns are matched against the oldest note of their kind.
    always @(negedge ref_clk) begin
        if (!sys_rst) begin
            if (cmdNop) take(1, 16'h0000);
            if (cmdBurstStop) take(3, 16'h0000);
            if (cmdModeLoad) take(4, {2'h0, burstLenCode, burstOrder, readLatencyCode, testModeCode,
                writeBurstSingle, refreshBanks});
            if (cmdAutoRefresh) take(5, {15'h0000, refreshPulse});
            if (colValid && !pageRun) take(6, {7'h00, burstActive, colAddr});
            if (colValid && pageRun) check({8'h00, colAddr}, {8'h00, pagePrev + 8'h01});
            if (colValid) pagePrev = colAddr;
            if (cmdDeselect) deselCnt++;
            if (refreshPulse) pulses++;
        end
    end
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        int k, i, cnt;
        logic [31:0] r;
        logic [12:0] d;
        logic sel;
        pageRun = 1'b0;
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(negedge ref_clk);
        check({2'h0, burstLenCode, burstOrder, readLatencyCode, testModeCode, writeBurstSingle, refreshBanks},
            16'h000f);
        for (k = 0; k < 16; k++) begin
            r = xs();
            d = r[12:0];
            d[2:0] = {1'b0, k[1:0]};
            d[6:4] = {2'h1, r[20]};
            d[12:11] = k[3:2];
            ldMode(d);
            burst(r[21], r[30], r[29:22]);
            repeat (10) @(posedge ref_clk);
        end
        ldMode(13'h0033);
        expQ[3].push_back(16'h0000);
        burst(1'b1, 1'b1, 8'hc3);
        send(3'h2, 13'h0000);
        repeat (12) @(posedge ref_clk);
        for (k = 0; k < 3; k++) begin
            ldMode(k == 1 ? 13'h0027 : k == 2 ? 13'h003f : 13'h0037);
            pageRun = 1'b1;
            pagePrev = 8'hf7;
            burst(k != 0, 1'b0, 8'hf8);
            repeat (14) @(posedge ref_clk);
            expQ[3].push_back(16'h0000);
            send(3'h2, 13'h0000);
            cnt = 0;
            for (i = 0; i < 40 && burstActive !== 1'b0; i++) begin
                @(negedge ref_clk);
                if (colValid === 1'b0 && burstActive === 1'b1) cnt++;
            end
            if (burstActive !== 1'b0) stall();
            check(16'(cnt), k == 0 ? 16'h0000 : k == 1 ? 16'h0002 : 16'h0003);
            pageRun = 1'b0;
        end
        for (k = 0; k < 4; k++) begin
            r = xs();
            sel = k[0] ^ (k[1] & r[0]);
            expQ[sel ? 1 : 3].push_back(16'h0000);
            send({1'b0, ~sel, 1'b0}, r[12:0]);
        end
        repeat (6) @(posedge ref_clk);
        cnt = deselCnt;
        repeat (20) @(posedge ref_clk);
        check(16'(deselCnt - cnt), 16'h0014);
        for (k = 0; k < 3; k++) begin
            expQ[5].push_back(16'h0001);
            for (i = 0; i < TRC; i++) expQ[1].push_back(16'h0000);
            r = xs();
            send(3'h4, r[12:0]);
        end
        repeat (10) @(posedge ref_clk);
        cnt = pulses;
        send(3'h5, 13'h0000);
        for (i = 0; i < 20 && selfRefreshActive !== 1'b1; i++) @(posedge ref_clk);
        if (selfRefreshActive !== 1'b1) stall();
        repeat (3 * TICK + 2) @(posedge ref_clk);
        check(16'(pulses - cnt >= 3), 16'h0001);
        send(3'h6, 13'h0000);
        for (i = 0; i < 20 && selfRefreshActive !== 1'b0; i++) @(posedge ref_clk);
        if (selfRefreshActive !== 1'b0) stall();
        ldMode(13'h0822);
        burst(1'b1, 1'b0, 8'h3d);
        repeat (12) @(posedge ref_clk);
        check({5'h00, refreshRow}, 16'(pulses));
        for (k = 1; k < 7; k++) check(16'(expQ[k].size()), 16'h0000);
        close_out();
    end
endmodule
